// file: shared/bqw_pkg.sv
// shared constants and types for the biquad and window engine and its host end
package bqw_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int ACC_W = 40;
  localparam int WR_W = ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 8;
  localparam int MEM_WORDS = 32768;
  localparam int FRAC_BITS = 15;

  // ---------------------------------------------------------------
  // commands
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    cmd_biquad_direct_form1,
    cmd_biquad_canonic,
    cmd_biquad_canonic_bias_minmax,
    cmd_mirrored_window
  } bqw_cmd_t;

  // ---------------------------------------------------------------
  // coefficient structure, halfword index from the coefficient pointer
  // ---------------------------------------------------------------
  localparam int COEF_B0 = 0;
  localparam int COEF_B1 = 1;
  localparam int COEF_B2 = 2;
  localparam int COEF_A1 = 3;
  localparam int COEF_A2 = 4;
  localparam int COEF_A0 = 5;
  localparam int COEF_BIAS = 6;
  localparam int COEF_WORDS = 7;

  // ---------------------------------------------------------------
  // state structures, halfword index from the state pointer
  // ---------------------------------------------------------------
  localparam int ST_X1 = 0;
  localparam int ST_X2 = 1;
  localparam int ST_Y1 = 2;
  localparam int ST_Y2 = 3;
  localparam int ST_W1 = 0;
  localparam int ST_W2 = 1;
  localparam int ST_MIN0 = 2;
  localparam int ST_MAX0 = 3;
  localparam int ST_MIN1 = 4;
  localparam int ST_MAX1 = 5;
  localparam int ST_WORDS = 6;

  // words moved per command
  localparam logic [3:0] DF1_COEFS = 4'h5;
  localparam logic [3:0] DF1_STATES = 4'h4;
  localparam logic [3:0] DF2_COEFS = 4'h6;
  localparam logic [3:0] DF2_STATES = 4'h2;
  localparam logic [3:0] EXT_COEFS = 4'h7;
  localparam logic [3:0] EXT_STATES = 4'h6;

  // ---------------------------------------------------------------
  // arithmetic and address constants
  // ---------------------------------------------------------------
  localparam logic signed [ACC_W-1:0] ACC_Q15_HI = 40'sh00_0000_7FFF;
  localparam logic signed [ACC_W-1:0] ACC_Q15_LO = 40'shFF_FFFF_8000;
  localparam logic [15:0] Q15_MAX = 16'h7FFF;
  localparam logic [15:0] Q15_MIN = 16'h8000;
  localparam logic [15:0] HALF_STEP = 16'h0002;
  localparam logic [15:0] WORD_ALIGN = 16'hFFFC;
  localparam logic [15:0] UNIT_STRIDE = 16'h0001;
  localparam logic [15:0] EVEN_MASK = 16'hFFFE;
endpackage

// file: shared/bqw_link_if.sv
// link between the filter engine and the host end that owns the shared memory
`timescale 1ns/1ps
interface bqw_link_if;
  import bqw_pkg::*;
  logic cmd_valid;
  logic cmd_ready;
  bqw_cmd_t cmd_op;
  logic [15:0] cmd_x;
  logic [15:0] cmd_z;
  logic [15:0] cmd_c;
  logic [15:0] cmd_s;
  logic [15:0] cmd_n;
  logic [15:0] cmd_k;
  logic [15:0] cmd_stride;
  logic done;
  logic rd_req;
  logic [15:0] rd_addr;
  logic rd_valid;
  logic [15:0] rd_data;
  logic wr_valid;
  logic wr_ready;
  logic [15:0] wr_addr;
  logic [15:0] wr_data;

  modport engine (
    input cmd_valid, cmd_op, cmd_x, cmd_z, cmd_c, cmd_s, cmd_n, cmd_k, cmd_stride,
    output cmd_ready, done, rd_req, rd_addr, wr_valid, wr_addr, wr_data,
    input rd_valid, rd_data, wr_ready
  );
  modport host (
    output cmd_valid, cmd_op, cmd_x, cmd_z, cmd_c, cmd_s, cmd_n, cmd_k, cmd_stride,
    input cmd_ready, done, rd_req, rd_addr, wr_valid, wr_addr, wr_data,
    output rd_valid, rd_data, wr_ready
  );
endinterface

// file: logic/bqw_engine.sv
// filter engine end: write fifo and biquad / window sequencer
//
// Contract
// - feedback adds stored A terms (denominator minus)
// - A1 and B1 products are added twice
// - A2 of -1 and A0 below one work
// - N pairs give 2N Q.15 output samples
// - load state first, write it back after
// - direct form 1 input steps by signed stride
// - host gives aligned 16-bit vector pointers
// - canonic form scales output by A0
// - extended form adds bias after A0 scaling
// - extended state holds extremes, loaded and stored
// - even and odd samples track separate extremes
// - host merges even and odd extremes
// - window coefficient n hits n and mirror
// - host gives even half-window tap count
// - host gives even pair count for window
// - direct form 1 reads X, writes Z
// - host prescales B terms, no input gain
`timescale 1ns/1ps

// ---------------------------------------------------------------
// write fifo
// ---------------------------------------------------------------
module bqw_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } bqw_fifo_st_t;
  bqw_fifo_st_t s;
  bqw_fifo_st_t next_s;
  logic push;
  logic pop;

  // handshakes straight from the count
  assign in_ready_o = (s.cnt != CW'(D));
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o = s.mem[s.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointers wrap at depth so D need not be a power of two
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp = (s.wp == AW'(D - 1)) ? '0 : s.wp + AW'(1);
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + AW'(1);
    end
    next_s.cnt = s.cnt + CW'(push) - CW'(pop);
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ---------------------------------------------------------------
// engine
// ---------------------------------------------------------------
module bqw_engine
  import bqw_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  bqw_link_if.engine link,
  output logic busy_o,
  output logic [16:0] progress_o
);
  typedef enum logic [3:0] {
    st_idle, st_load, st_start, st_rdc, st_rdx, st_calc, st_push, st_store, st_drain, st_done
  } bqw_eng_state_t;

  typedef struct packed {
    bqw_eng_state_t st;
    bqw_cmd_t cmd;
    logic [15:0] x_addr;
    logic [15:0] mirror;
    logic [15:0] z_addr;
    logic [15:0] c_ptr;
    logic [15:0] s_ptr;
    logic [15:0] stride;
    logic [15:0] rd_addr;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic [15:0] xs;
    logic [15:0] cw;
    logic [16:0] cnt;
    logic [16:0] total;
    logic [3:0] ld;
    logic [3:0] nc;
    logic [3:0] ns;
    logic sub;
    logic pend;
    logic [COEF_WORDS-1:0][15:0] coef;
    logic [ST_WORDS-1:0][15:0] sv;
  } bqw_eng_t;

  bqw_eng_t s;
  bqw_eng_t next_s;
  logic fin_valid;
  logic fin_ready;
  logic [WR_W-1:0] fin_data;
  logic fout_valid;
  logic [WR_W-1:0] fout_data;
  logic signed [ACC_W-1:0] acc_a;
  logic signed [ACC_W-1:0] acc_b;
  logic signed [ACC_W-1:0] acc_c;
  logic [15:0] w;
  logic [15:0] v;
  logic [15:0] y;
  logic [15:0] st_addr;
  logic is_ext;
  logic is_win;

  // signed Q.15 product carried at accumulator width
  function automatic logic signed [ACC_W-1:0] mul(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    mul = ACC_W'(p);
  endfunction

  // Q.15 value lifted to the product scale
  function automatic logic signed [ACC_W-1:0] q30(input logic [15:0] a);
    q30 = $signed({{9{a[15]}}, a, 15'h0000});
  endfunction

  // saturate rather than wrap, so an overshoot never flips sign
  function automatic logic [15:0] sat(input logic signed [ACC_W-1:0] acc);
    logic signed [ACC_W-1:0] t;
    t = acc >>> FRAC_BITS;
    if (t > ACC_Q15_HI) begin
      sat = Q15_MAX;
    end else if (t < ACC_Q15_LO) begin
      sat = Q15_MIN;
    end else begin
      sat = t[15:0];
    end
  endfunction

  // write path buffer; a stalled host back-pressures the sequencer
  bqw_fifo #(.W(WR_W), .D(FIFO_DEPTH)) bqw_fifo_i (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(fin_valid),
    .in_ready_o(fin_ready),
    .in_data_i(fin_data),
    .out_valid_o(fout_valid),
    .out_ready_i(link.wr_ready),
    .out_data_o(fout_data)
  );

  // link side outputs
  assign link.cmd_ready = (s.st == st_idle);
  assign link.done = (s.st == st_done);
  assign link.rd_req = (s.st == st_load || s.st == st_rdc || s.st == st_rdx) && !s.pend;
  assign link.rd_addr = s.rd_addr;
  assign link.wr_valid = fout_valid;
  assign link.wr_addr = fout_data[WR_W-1:DATA_W];
  assign link.wr_data = fout_data[DATA_W-1:0];
  assign busy_o = (s.st != st_idle);
  assign progress_o = s.cnt;
  assign is_ext = (s.cmd == cmd_biquad_canonic_bias_minmax);
  assign is_win = (s.cmd == cmd_mirrored_window);
  assign st_addr = s.s_ptr + {11'h000, s.ld, 1'b0};

  // ---------------------------------------------------------------
  // datapath, evaluated from registered operands
  // ---------------------------------------------------------------
  always_comb begin
    acc_a = '0;
    acc_b = '0;
    acc_c = '0;
    w = 16'h0000;
    v = 16'h0000;
    y = 16'h0000;
    if (s.cmd == cmd_biquad_direct_form1) begin
      // no input gain stage: the B terms already carry it
      acc_a = mul(s.coef[COEF_B0], s.xs) + (mul(s.coef[COEF_B1], s.sv[ST_X1]) <<< 1)
            + mul(s.coef[COEF_B2], s.sv[ST_X2])
            + (mul(s.coef[COEF_A1], s.sv[ST_Y1]) <<< 1)
            + mul(s.coef[COEF_A2], s.sv[ST_Y2]);
      y = sat(acc_a);
    end else if (is_win) begin
      acc_a = mul(s.cw, s.xs);
      y = sat(acc_a);
    end else begin
      // single delay line: w feeds both the feedback and the output taps
      acc_a = q30(s.xs) + (mul(s.coef[COEF_A1], s.sv[ST_W1]) <<< 1)
            + mul(s.coef[COEF_A2], s.sv[ST_W2]);
      w = sat(acc_a);
      acc_b = mul(s.coef[COEF_B0], w) + (mul(s.coef[COEF_B1], s.sv[ST_W1]) <<< 1)
            + mul(s.coef[COEF_B2], s.sv[ST_W2]);
      v = sat(acc_b);
      acc_c = mul(s.coef[COEF_A0], v) + (is_ext ? q30(s.coef[COEF_BIAS]) : '0);
      y = sat(acc_c);
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    fin_valid = 1'b0;
    fin_data = {s.wr_addr, s.wr_data};
    // one read outstanding; the request fires once per armed address
    if (link.rd_req) begin
      next_s.pend = 1'b1;
    end
    unique case (s.st)
      st_idle: begin
        if (link.cmd_valid) begin
          next_s.cmd = link.cmd_op;
          next_s.x_addr = link.cmd_x;
          next_s.mirror = link.cmd_x + {link.cmd_n[13:0], 2'b00} - HALF_STEP;
          next_s.z_addr = link.cmd_z;
          next_s.c_ptr = link.cmd_c;
          next_s.s_ptr = link.cmd_s;
          next_s.cnt = '0;
          next_s.ld = '0;
          next_s.pend = 1'b0;
          next_s.rd_addr = link.cmd_c;
          next_s.total = {link.cmd_n, 1'b0};
          next_s.stride = UNIT_STRIDE;
          next_s.st = st_load;
          unique case (link.cmd_op)
            cmd_biquad_direct_form1: begin
              next_s.nc = DF1_COEFS;
              next_s.ns = DF1_STATES;
              next_s.stride = link.cmd_stride;
            end
            cmd_biquad_canonic: begin
              next_s.nc = DF2_COEFS;
              next_s.ns = DF2_STATES;
            end
            cmd_biquad_canonic_bias_minmax: begin
              next_s.nc = EXT_COEFS;
              next_s.ns = EXT_STATES;
            end
            cmd_mirrored_window: begin
              next_s.nc = '0;
              next_s.ns = '0;
              next_s.total = {1'b0, link.cmd_k};
              next_s.st = st_start;
            end
          endcase
        end
      end
      st_load: begin
        if (s.pend && link.rd_valid) begin
          if (s.ld < s.nc) begin
            next_s.coef[s.ld] = link.rd_data;
          end else begin
            next_s.sv[s.ld - s.nc] = link.rd_data;
          end
          next_s.ld = s.ld + 4'h1;
          next_s.pend = 1'b0;
          if (s.ld + 4'h1 < s.nc) begin
            next_s.rd_addr = s.c_ptr + {11'h000, s.ld + 4'h1, 1'b0};
          end else begin
            next_s.rd_addr = s.s_ptr + {11'h000, s.ld + 4'h1 - s.nc, 1'b0};
          end
          if (s.ld + 4'h1 == s.nc + s.ns) begin
            next_s.st = st_start;
          end
        end
      end
      st_start: begin
        next_s.ld = '0;
        next_s.pend = 1'b0;
        if (s.total == '0) begin
          next_s.st = st_store;
        end else if (is_win) begin
          next_s.rd_addr = s.c_ptr;
          next_s.st = st_rdc;
        end else begin
          next_s.rd_addr = s.x_addr;
          next_s.st = st_rdx;
        end
      end
      st_rdc: begin
        if (s.pend && link.rd_valid) begin
          next_s.cw = link.rd_data;
          next_s.sub = 1'b0;
          next_s.pend = 1'b0;
          next_s.rd_addr = s.x_addr;
          next_s.st = st_rdx;
        end
      end
      st_rdx: begin
        if (s.pend && link.rd_valid) begin
          next_s.xs = link.rd_data;
          next_s.pend = 1'b0;
          next_s.st = st_calc;
        end
      end
      st_calc: begin
        next_s.wr_data = y;
        next_s.wr_addr = is_win ? (s.sub ? s.mirror : s.x_addr) : s.z_addr;
        if (s.cmd == cmd_biquad_direct_form1) begin
          next_s.sv[ST_X2] = s.sv[ST_X1];
          next_s.sv[ST_X1] = s.xs;
          next_s.sv[ST_Y2] = s.sv[ST_Y1];
          next_s.sv[ST_Y1] = y;
        end else if (!is_win) begin
          next_s.sv[ST_W2] = s.sv[ST_W1];
          next_s.sv[ST_W1] = w;
        end
        if (is_ext && !s.cnt[0]) begin
          if ($signed(y) < $signed(s.sv[ST_MIN0])) next_s.sv[ST_MIN0] = y;
          if ($signed(y) > $signed(s.sv[ST_MAX0])) next_s.sv[ST_MAX0] = y;
        end
        if (is_ext && s.cnt[0]) begin
          if ($signed(y) < $signed(s.sv[ST_MIN1])) next_s.sv[ST_MIN1] = y;
          if ($signed(y) > $signed(s.sv[ST_MAX1])) next_s.sv[ST_MAX1] = y;
        end
        next_s.st = st_push;
      end
      st_push: begin
        fin_valid = 1'b1;
        if (fin_ready) begin
          next_s.st = st_rdx;
          if (is_win && !s.sub) begin
            next_s.sub = 1'b1;
            next_s.rd_addr = s.mirror;
          end else if (is_win) begin
            next_s.cnt = s.cnt + 17'h00001;
            next_s.x_addr = s.x_addr + HALF_STEP;
            next_s.mirror = s.mirror - HALF_STEP;
            next_s.c_ptr = s.c_ptr + HALF_STEP;
            next_s.rd_addr = s.c_ptr + HALF_STEP;
            next_s.st = (s.cnt + 17'h00001 == s.total) ? st_store : st_rdc;
          end else begin
            next_s.cnt = s.cnt + 17'h00001;
            next_s.z_addr = s.z_addr + HALF_STEP;
            // after the odd element jump by stride pairs from the pair base
            next_s.x_addr = s.cnt[0] ? s.x_addr - HALF_STEP + {s.stride[13:0], 2'b00}
                                     : s.x_addr + HALF_STEP;
            next_s.rd_addr = next_s.x_addr;
            if (s.cnt + 17'h00001 == s.total) begin
              next_s.st = st_store;
            end
          end
        end
      end
      st_store: begin
        // state words share the fifo so they land after the last sample
        fin_data = {st_addr, s.sv[s.ld]};
        if (s.ld == s.ns) begin
          next_s.st = st_drain;
        end else begin
          fin_valid = 1'b1;
          if (fin_ready) begin
            next_s.ld = s.ld + 4'h1;
          end
        end
      end
      st_drain: begin
        // done only once every write has left, so the host sees final memory
        if (!fout_valid) begin
          next_s.st = st_done;
        end
      end
      st_done: begin
        next_s.st = st_idle;
      end
      default: begin
        next_s.st = st_idle;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// file: logic/bqw_host.sv
// host end: shared memory, command issue and overall extremes
`timescale 1ns/1ps
module bqw_host
  import bqw_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  bqw_link_if.host link,
  input wire logic mem_we_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  output logic [15:0] mem_rdata_o,
  input wire logic start_i,
  input wire bqw_cmd_t cmd_i,
  input wire logic [15:0] x_ptr_i,
  input wire logic [15:0] z_ptr_i,
  input wire logic [15:0] c_ptr_i,
  input wire logic [15:0] s_ptr_i,
  input wire logic [15:0] count_i,
  input wire logic [15:0] taps_i,
  input wire logic [15:0] stride_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] all_min_o,
  output logic [15:0] all_max_o
);
  typedef struct packed {
    logic pend;
    logic busy;
    logic done;
    bqw_cmd_t cmd;
    logic [15:0] x;
    logic [15:0] z;
    logic [15:0] c;
    logic [15:0] s;
    logic [15:0] n;
    logic [15:0] k;
    logic [15:0] stride;
    logic rd_valid;
    logic [15:0] rd_data;
    logic [15:0] user_rdata;
    logic [15:0] amin;
    logic [15:0] amax;
  } bqw_host_t;

  bqw_host_t s;
  bqw_host_t next_s;
  logic [15:0] mem [MEM_WORDS];
  logic [14:0] ext_base;
  logic [15:0] min0;
  logic [15:0] min1;
  logic [15:0] max0;
  logic [15:0] max1;

  // ---------------------------------------------------------------
  // link outputs
  // ---------------------------------------------------------------
  assign link.cmd_valid = s.pend;
  assign link.cmd_op = s.cmd;
  assign link.cmd_x = s.x;
  assign link.cmd_z = s.z;
  assign link.cmd_c = s.c;
  assign link.cmd_s = s.s;
  assign link.cmd_n = s.n;
  assign link.cmd_k = s.k;
  assign link.cmd_stride = s.stride;
  assign link.rd_valid = s.rd_valid;
  assign link.rd_data = s.rd_data;
  // user writes win the memory port; the engine's fifo absorbs the stall
  assign link.wr_ready = !mem_we_i;
  assign mem_rdata_o = s.user_rdata;
  assign busy_o = s.busy;
  assign done_o = s.done;
  assign all_min_o = s.amin;
  assign all_max_o = s.amax;

  // extended state words of the finished command
  assign ext_base = s.s[15:1];
  assign min0 = mem[ext_base + 15'(ST_MIN0)];
  assign max0 = mem[ext_base + 15'(ST_MAX0)];
  assign min1 = mem[ext_base + 15'(ST_MIN1)];
  assign max1 = mem[ext_base + 15'(ST_MAX1)];

  // ---------------------------------------------------------------
  // command and read answer logic
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.rd_valid = link.rd_req;
    next_s.rd_data = mem[link.rd_addr[15:1]];
    next_s.user_rdata = mem[mem_addr_i[15:1]];
    // a start while a command runs is dropped
    if (start_i && !s.busy) begin
      next_s.pend = 1'b1;
      next_s.busy = 1'b1;
      next_s.cmd = cmd_i;
      next_s.x = x_ptr_i & WORD_ALIGN;
      next_s.z = z_ptr_i & WORD_ALIGN;
      next_s.c = c_ptr_i & WORD_ALIGN;
      next_s.s = s_ptr_i & WORD_ALIGN;
      next_s.n = (cmd_i == cmd_mirrored_window) ? (count_i & EVEN_MASK) : count_i;
      next_s.k = taps_i & EVEN_MASK;
      next_s.stride = stride_i;
    end
    if (s.pend && link.cmd_ready) begin
      next_s.pend = 1'b0;
    end
    if (s.busy && !s.pend && link.done) begin
      next_s.busy = 1'b0;
      next_s.done = 1'b1;
      if (s.cmd == cmd_biquad_canonic_bias_minmax) begin
        // merge even and odd extremes into overall ones
        next_s.amin = ($signed(min0) < $signed(min1)) ? min0 : min1;
        next_s.amax = ($signed(max0) > $signed(max1)) ? max0 : max1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // shared memory, no reset: contents are loaded by the user
  always_ff @(posedge clk_sys_i) begin
    if (mem_we_i) begin
      mem[mem_addr_i[15:1]] <= mem_wdata_i;
    end else if (link.wr_valid) begin
      mem[link.wr_addr[15:1]] <= link.wr_data;
    end
  end
endmodule

// file: bench/bqw_link_assertions.sv
// checker on the link between the engine and host ends
`timescale 1ns/1ps
module bqw_link_chk
  import bqw_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire bqw_cmd_t cmd_op,
  input wire logic done,
  input wire logic rd_req,
  input wire logic [15:0] rd_addr,
  input wire logic rd_valid,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data
);
  // ---------------------------------------------------------------
  // link timing
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  // host answers every read one cycle on, one read in flight
  chk_rd_answer: assert property (rd_req |=> rd_valid)
    else $error("read left unanswered");
  chk_rd_single: assert property (rd_req |=> !rd_req)
    else $error("second read while one outstanding");
  // a stalled write must not change under the host
  chk_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr)
    && $stable(wr_data))
    else $error("stalled write changed");
  chk_rd_align: assert property (rd_req |-> !rd_addr[0])
    else $error("odd read address");
  chk_wr_align: assert property (wr_valid |-> !wr_addr[0])
    else $error("odd write address");
  // every accepted command keeps the engine out of idle for at least two cycles
  chk_cmd_leave: assert property (cmd_valid && cmd_ready |=> !cmd_ready [*2])
    else $error("engine stayed idle after command");
  chk_done_drain: assert property (done |-> !wr_valid && !rd_req)
    else $error("done before writes drained");
  chk_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  chk_idle_quiet: assert property (cmd_ready |-> !rd_req)
    else $error("read issued while idle");
  cover property (cmd_valid && cmd_ready && cmd_op == cmd_biquad_direct_form1);
  cover property (cmd_valid && cmd_ready && cmd_op == cmd_biquad_canonic_bias_minmax);
  cover property (cmd_valid && cmd_ready && cmd_op == cmd_mirrored_window);
endmodule

// file: bench/tb_biquad_iir_and_window_engine.sv
// testbench joining the engine and host ends over the link
`timescale 1ns/1ps
module tb_biquad_iir_and_window_engine;
  import bqw_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic mem_we_i = 1'b0;
  logic start_i = 1'b0;
  logic [15:0] mem_addr_i = 16'h0000, mem_wdata_i = 16'h0000, mem_rdata_o;
  logic [15:0] cnt = 16'h0000, taps = 16'h0000, all_min_o, all_max_o;
  bqw_cmd_t cmd_i = cmd_biquad_direct_form1;
  logic busy_o, done_o, busy_e;
  logic [16:0] prog;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  bqw_link_if link();
  bqw_engine bqw_engine_i(.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link),
    .busy_o(busy_e), .progress_o(prog));
  // fixed pointers: X, Z, C, S regions apart
  bqw_host bqw_host_i(.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link),
    .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
    .mem_rdata_o(mem_rdata_o), .start_i(start_i), .cmd_i(cmd_i), .x_ptr_i(16'h0100),
    .z_ptr_i(16'h0200), .c_ptr_i(16'h0300), .s_ptr_i(16'h0400), .count_i(cnt),
    .taps_i(taps), .stride_i(16'h0002), .busy_o(busy_o), .done_o(done_o),
    .all_min_o(all_min_o), .all_max_o(all_max_o));
  bqw_link_chk bqw_link_chk_i(.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd_op(link.cmd_op),
    .done(link.done), .rd_req(link.rd_req), .rd_addr(link.rd_addr),
    .rd_valid(link.rd_valid), .wr_valid(link.wr_valid), .wr_ready(link.wr_ready),
    .wr_addr(link.wr_addr), .wr_data(link.wr_data));
  // ---------------------------------------------------------------
  // clock, timeout and report
  // ---------------------------------------------------------------
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // tests need a few hundred cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    mem_we_i = 1'b1;
    mem_addr_i = a;
    mem_wdata_i = d;
    @(negedge clk_sys_i);
    mem_we_i = 1'b0;
  endtask
  // data one edge after address
  task automatic chk(input string nm, input logic [15:0] a, input logic [15:0] e);
    @(negedge clk_sys_i);
    mem_addr_i = a;
    @(negedge clk_sys_i);
    cmp(nm, e, mem_rdata_o);
  endtask
  task automatic clr;
    for (int i = 0; i < 8; i++) begin
      wr(16'h0300 + 16'(2 * i), 16'h0000);
      wr(16'h0400 + 16'(2 * i), 16'h0000);
    end
  endtask
  task automatic run(input bqw_cmd_t op, input logic [15:0] n, input logic [15:0] k);
    @(negedge clk_sys_i);
    cmd_i = op;
    cnt = n;
    taps = k;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    cmp("busy", 16'h0001, {15'h0000, busy_o});
    mem_we_i = 1'b1; // rewrites last word, stalls fifo
    repeat (40) @(negedge clk_sys_i);
    cmp("eng busy", 16'h0001, {15'h0000, busy_e});
    mem_we_i = 1'b0;
    for (int i = 0; i < 2000 && done_o !== 1'b1; i++) begin
      @(negedge clk_sys_i);
    end
    cmp("done", 16'h0001, {15'h0000, done_o});
    cmp("progress", (op == cmd_mirrored_window) ? k : n << 1, prog[15:0]);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // feedback positive and doubled; stride 2 skips a pair
  task automatic t_df1;
    clr();
    wr(16'h0100, 16'h4000);
    wr(16'h0102, 16'h0000);
    wr(16'h0108, 16'h4000);
    wr(16'h010A, 16'h0000);
    wr(16'h0300, 16'h4000);
    wr(16'h0306, 16'h2000);
    run(cmd_biquad_direct_form1, 16'h0002, 16'h0000);
    chk("df1 z0", 16'h0200, 16'h2000);
    chk("df1 z1", 16'h0202, 16'h1000);
    chk("df1 z2", 16'h0204, 16'h2800);
    chk("df1 y1", 16'h0404, 16'h1400);
    chk("df1 y2", 16'h0406, 16'h2800);
  endtask
  // extremes seeded inverted
  task automatic t_bq2(input bqw_cmd_t op, input logic [15:0] e0, input logic [15:0] e1);
    clr();
    wr(16'h0100, 16'h4000);
    wr(16'h0102, 16'hC000);
    wr(16'h0300, 16'h4000);
    wr(16'h030A, 16'h4000);
    wr(16'h030C, 16'h0100);
    wr(16'h0404, 16'h7FFF);
    wr(16'h0406, 16'h8000);
    wr(16'h0408, 16'h7FFF);
    wr(16'h040A, 16'h8000);
    run(op, 16'h0001, 16'h0000);
    chk("bq2 z0", 16'h0200, e0);
    chk("bq2 z1", 16'h0202, e1);
  endtask
  task automatic t_win;
    for (int i = 0; i < 4; i++) begin
      wr(16'h0100 + 16'(2 * i), 16'h4000);
    end
    wr(16'h0300, 16'h4000);
    wr(16'h0302, 16'h2000);
    run(cmd_mirrored_window, 16'h0002, 16'h0002);
    chk("win x0", 16'h0100, 16'h2000);
    chk("win x1", 16'h0102, 16'h1000);
    chk("win x2", 16'h0104, 16'h1000);
    chk("win x3", 16'h0106, 16'h2000);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    t_df1();
    t_bq2(cmd_biquad_canonic, 16'h1000, 16'hF000);
    t_bq2(cmd_biquad_canonic_bias_minmax, 16'h1100, 16'hF100);
    chk("min0", 16'h0404, 16'h1100);
    chk("max1", 16'h040A, 16'hF100);
    cmp("all min", 16'hF100, all_min_o);
    cmp("all max", 16'h1100, all_max_o);
    t_win();
    complete_run();
  end
endmodule
